// ### fso_core.sv
// Purpose: Security-area erase/program/read, resume and two-step software reset
// Assumes: Host keeps chip select high at least 200 ns between frames
// Notes: Link logic runs on the shift clock; frame results are read by the
//        system clock only after chip select has risen and the shift clock is idle
// Operation
// - Resume taken only when halted flag set and operation-active bit clear.
// - Accepted resume clears halted flag, raises active within 200 ns, finishes operation.
// - Resume with no suspension in force is ignored.
// - Three 2048-byte areas, selected by address bits 23..11, offset bits 10..0.
// - Erase runs only if chip select rises right after last address bit.
// - Chip select rise starts timed erase; active bit high except while suspended, permit cleared.
// - Set lock bit makes erase and program of that area ignored.
// - Program frame is opcode, address, then at least one data byte.
// - Chip select rise starts timed program; active bit high except while suspended, permit cleared.
// - Each area is four program pages.
// - Read is opcode, address, dummy byte; data driven on falling edges.
// - Read offset advances per byte and wraps from 7FF to 000.
// - Reset needs enable opcode in one frame, reset opcode in the next.
// - Accepted reset aborts operation and drops permit, suspension and volatile settings.
// - During reset recovery every command is rejected.
`timescale 1ns/1ps
module fso_core #(
    parameter int ERASE_CYCLES = fso_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES = fso_pkg::PROG_CYCLES,
    parameter int RST_CYCLES = fso_pkg::RST_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic si,
    input wire logic [2:0] otpLockBits,
    input wire logic addrWidthSel,
    input wire logic writePermitSet,
    input wire logic suspendReq,
    output logic soData,
    output logic soOe,
    output logic opActive,
    output logic writePermit,
    output logic haltedOp,
    output logic volatileLoss
);
    // Last cycle of the resume window, as a plain constant for the delay bound
    localparam int RESUME_LAST = fso_pkg::RESUME_CYCLES - 1;

    // Reset release synchroniser; only the second stage is used
    logic rstS1_r;
    logic rstN;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstS1_r <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstS1_r <= 1'b1;
            rstN <= rstS1_r;
        end
    end

    // ---------------- Link domain (shift clock) ----------------
    logic linkClr;
    logic [15:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] opcode_r, opcode_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [15:0] frameBits_r, frameBits_nxt;
    logic [7:0] dataSh_r, dataSh_nxt;
    logic [8:0] byteNo_r, byteNo_nxt;
    logic [10:0] rdPtr_r, rdPtr_nxt;
    logic aw4S1_r, aw4S2_r, blkS1_r, blkS2_r;
    logic blockRead_r, blockRead_nxt;
    logic [15:0] addrEnd, dOff;
    logic inAddr, inData, byteDone, bufClr, bufWr, rdAdv;
    logic [8:0] bufIdx;
    logic [7:0] bufByte, rdByte;
    logic [1:0] rdArea;
    logic rdAddrOk;
    logic [7:0] pageBuf_r [0:fso_pkg::PAGE_BYTES-1];
    logic [7:0] mem_r [0:fso_pkg::MEM_BYTES-1];

    // Chip select high clears the frame counter; captured frame data is kept
    assign linkClr = csN | ~rstN;

    // Frame decode in the link domain
    always_comb begin
        addrEnd = fso_pkg::OPCODE_BITS + (aw4S2_r ? fso_pkg::ADDR_BITS_4B : fso_pkg::ADDR_BITS_3B);
        inAddr = (bitCnt_r >= fso_pkg::OPCODE_BITS) && (bitCnt_r < addrEnd);
        inData = bitCnt_r >= addrEnd;
        dOff = bitCnt_r - addrEnd;
        byteDone = inData && (dOff[2:0] == 3'h7);
        bitCnt_nxt = (bitCnt_r == fso_pkg::BIT_CNT_MAX) ? bitCnt_r : bitCnt_r + 16'h0001;
        frameBits_nxt = bitCnt_nxt;
        opcode_nxt = (bitCnt_r < fso_pkg::OPCODE_BITS) ? {opcode_r[6:0], si} : opcode_r;
        addr_nxt = addr_r;
        if (bitCnt_r < fso_pkg::OPCODE_BITS) begin
            addr_nxt = 32'h0000_0000; // Three-byte frames leave the top byte zero
        end else if (inAddr) begin
            addr_nxt = {addr_r[30:0], si};
        end
        dataSh_nxt = {dataSh_r[6:0], si};
        bufWr = byteDone && (opcode_r == fso_pkg::OP_PROG);
        bufIdx = addr_r[8:0] + byteNo_r; // Wraps inside the page like a page program
        bufByte = {dataSh_r[6:0], si};
        bufClr = (bitCnt_r == fso_pkg::OPCODE_BITS - 16'h0001) && ({opcode_r[6:0], si} == fso_pkg::OP_PROG);
        byteNo_nxt = (bitCnt_r < fso_pkg::OPCODE_BITS) ? 9'h000 : (bufWr ? byteNo_r + 9'h001 : byteNo_r);
        rdAdv = (opcode_r == fso_pkg::OP_READ) && byteDone && (dOff >= fso_pkg::DUMMY_BITS);
        if (bitCnt_r == addrEnd) begin
            rdPtr_nxt = addr_r[10:0];
        end else if (rdAdv) begin
            rdPtr_nxt = rdPtr_r + 11'h001;
        end else begin
            rdPtr_nxt = rdPtr_r;
        end
    end

    // Frame bit counter, cleared while chip select is high
    always_ff @(posedge sclk or posedge linkClr) begin
        if (linkClr) begin
            bitCnt_r <= 16'h0000;
        end else begin
            bitCnt_r <= bitCnt_nxt;
        end
    end

    // Captured frame fields; held after the frame for the system side to decode
    always_ff @(posedge sclk or negedge rstN) begin
        if (!rstN) begin
            opcode_r <= 8'h00;
            addr_r <= 32'h0000_0000;
            frameBits_r <= 16'h0000;
            dataSh_r <= 8'h00;
            byteNo_r <= 9'h000;
            rdPtr_r <= 11'h000;
            aw4S1_r <= 1'b0;
            aw4S2_r <= 1'b0;
            blkS1_r <= 1'b1;
            blkS2_r <= 1'b1;
        end else begin
            opcode_r <= opcode_nxt;
            addr_r <= addr_nxt;
            frameBits_r <= frameBits_nxt;
            dataSh_r <= dataSh_nxt;
            byteNo_r <= byteNo_nxt;
            rdPtr_r <= rdPtr_nxt;
            aw4S1_r <= addrWidthSel; // Settles within the opcode phase
            aw4S2_r <= aw4S1_r;
            blkS1_r <= blockRead_r;
            blkS2_r <= blkS1_r;
        end
    end

    // Page buffer, preset to erased so unsent bytes leave the array untouched
    genvar k;
    generate
        for (k = 0; k < fso_pkg::PAGE_BYTES; k++) begin : g_buf
            logic [7:0] bufNxt;
            always_comb begin
                bufNxt = pageBuf_r[k];
                if (bufClr) begin
                    bufNxt = fso_pkg::ERASED_BYTE;
                end else if (bufWr && (bufIdx == 9'(k))) begin
                    bufNxt = bufByte;
                end
            end
            always_ff @(posedge sclk or negedge rstN) begin
                if (!rstN) begin
                    pageBuf_r[k] <= 8'hFF;
                end else begin
                    pageBuf_r[k] <= bufNxt;
                end
            end
        end
    endgenerate

    // read data path, driven on falling edges
    logic soData_r, soData_nxt, soOe_r, soOe_nxt;
    always_comb begin
        rdArea = 2'(addr_r[13:12] - 2'h1);
        rdAddrOk = (addr_r[31:16] == 16'h0000) && (addr_r[15:12] >= fso_pkg::AREA_SEL_FIRST) &&
                   (addr_r[15:12] <= fso_pkg::AREA_SEL_LAST) && !addr_r[11];
        rdByte = rdAddrOk ? mem_r[{rdArea, rdPtr_r}] : fso_pkg::ERASED_BYTE;
        // Reads are refused while an operation or reset recovery is under way
        soOe_nxt = (opcode_r == fso_pkg::OP_READ) && inData && (dOff >= fso_pkg::DUMMY_BITS) &&
                   !blkS2_r && (bitCnt_r != fso_pkg::BIT_CNT_MAX);
        soData_nxt = soOe_nxt ? rdByte[3'h7 - dOff[2:0]] : 1'b0;
    end
    always_ff @(negedge sclk or posedge linkClr) begin
        if (linkClr) begin
            soData_r <= 1'b0;
            soOe_r <= 1'b0;
        end else begin
            soData_r <= soData_nxt;
            soOe_r <= soOe_nxt;
        end
    end
    assign soData = soData_r;
    assign soOe = soOe_r;

    // ---------------- System domain ----------------
    logic csS1_r, csS2_r, csS3_r, csRise;
    fso_pkg::fso_state_t state_r, state_nxt;
    logic [31:0] timer_r, timer_nxt, opLast;
    logic active_r, active_nxt, halted_r, halted_nxt, wel_r, wel_nxt;
    logic rstArm_r, rstArm_nxt, volLoss_r, volLoss_nxt;
    logic [1:0] area_r, area_nxt, page_r, page_nxt;
    logic eraseGo_r, eraseGo_nxt, progGo_r, progGo_nxt;
    logic [15:0] eraseBits, progMin;
    logic isResume, isRstEn, isRst, lockHit, eraseOk, progOk;

    // Chip select synchroniser; stage one feeds stage two only
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            csS1_r <= 1'b1;
            csS2_r <= 1'b1;
            csS3_r <= 1'b1;
        end else begin
            csS1_r <= csN;
            csS2_r <= csS1_r;
            csS3_r <= csS2_r;
        end
    end
    assign csRise = csS2_r & ~csS3_r;

    // Command qualification from the captured frame
    always_comb begin
        eraseBits = fso_pkg::OPCODE_BITS + (addrWidthSel ? fso_pkg::ADDR_BITS_4B : fso_pkg::ADDR_BITS_3B);
        progMin = eraseBits + 16'h0008;
        isResume = (opcode_r == fso_pkg::OP_RESUME) && (frameBits_r == fso_pkg::OPCODE_BITS);
        isRstEn = (opcode_r == fso_pkg::OP_RST_EN) && (frameBits_r == fso_pkg::OPCODE_BITS);
        isRst = (opcode_r == fso_pkg::OP_RST) && (frameBits_r == fso_pkg::OPCODE_BITS);
        lockHit = otpLockBits[rdArea];
        eraseOk = (state_r == fso_pkg::ST_IDLE) && wel_r && rdAddrOk && !lockHit &&
                  (opcode_r == fso_pkg::OP_ERASE) && (frameBits_r == eraseBits);
        progOk = (state_r == fso_pkg::ST_IDLE) && wel_r && rdAddrOk && !lockHit &&
                 (opcode_r == fso_pkg::OP_PROG) && (frameBits_r >= progMin);
        opLast = (state_r == fso_pkg::ST_ERASE) ? 32'(ERASE_CYCLES - 1) : 32'(PROG_CYCLES - 1);
    end

    // Operation engine next state
    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        active_nxt = active_r;
        halted_nxt = halted_r;
        wel_nxt = wel_r;
        rstArm_nxt = rstArm_r;
        area_nxt = area_r;
        page_nxt = page_r;
        volLoss_nxt = 1'b0;
        eraseGo_nxt = 1'b0;
        progGo_nxt = 1'b0;
        unique case (state_r)
            fso_pkg::ST_IDLE: begin
                if (writePermitSet) begin
                    wel_nxt = 1'b1;
                end
            end
            fso_pkg::ST_ERASE, fso_pkg::ST_PROG: begin
                // self-timed cycle; timer frozen while halted
                if (active_r) begin
                    if (timer_r == opLast) begin
                        state_nxt = fso_pkg::ST_IDLE;
                        active_nxt = 1'b0;
                        timer_nxt = 32'h0000_0000;
                    end else begin
                        timer_nxt = timer_r + 32'h0000_0001;
                        if (suspendReq && !halted_r) begin
                            halted_nxt = 1'b1;
                            active_nxt = 1'b0;
                        end
                    end
                end
            end
            fso_pkg::ST_RSTWAIT: begin
                if (timer_r == 32'(RST_CYCLES - 1)) begin
                    state_nxt = fso_pkg::ST_IDLE;
                    timer_nxt = 32'h0000_0000;
                end else begin
                    timer_nxt = timer_r + 32'h0000_0001;
                end
            end
        endcase
        if (csRise && (state_r != fso_pkg::ST_RSTWAIT)) begin
            // enable must come in the frame just before
            rstArm_nxt = isRstEn;
            if (isRst && rstArm_r) begin
                state_nxt = fso_pkg::ST_RSTWAIT;
                timer_nxt = 32'h0000_0000;
                active_nxt = 1'b0;
                halted_nxt = 1'b0;
                wel_nxt = 1'b0;
                volLoss_nxt = 1'b1;
            end else if (isResume && halted_r && !active_r) begin
                halted_nxt = 1'b0;
                active_nxt = 1'b1;
            end else if (eraseOk) begin
                state_nxt = fso_pkg::ST_ERASE;
                active_nxt = 1'b1;
                wel_nxt = 1'b0;
                timer_nxt = 32'h0000_0000;
                area_nxt = rdArea;
                eraseGo_nxt = 1'b1;
            end else if (progOk) begin
                state_nxt = fso_pkg::ST_PROG;
                active_nxt = 1'b1;
                wel_nxt = 1'b0;
                timer_nxt = 32'h0000_0000;
                area_nxt = rdArea;
                page_nxt = addr_r[10:9];
                progGo_nxt = 1'b1;
            end
        end
        blockRead_nxt = state_nxt != fso_pkg::ST_IDLE;
    end

    // Operation engine registers
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state_r <= fso_pkg::ST_IDLE;
            timer_r <= 32'h0000_0000;
            active_r <= 1'b0;
            halted_r <= 1'b0;
            wel_r <= 1'b0;
            rstArm_r <= 1'b0;
            area_r <= 2'h0;
            page_r <= 2'h0;
            volLoss_r <= 1'b0;
            eraseGo_r <= 1'b0;
            progGo_r <= 1'b0;
            blockRead_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            active_r <= active_nxt;
            halted_r <= halted_nxt;
            wel_r <= wel_nxt;
            rstArm_r <= rstArm_nxt;
            area_r <= area_nxt;
            page_r <= page_nxt;
            volLoss_r <= volLoss_nxt;
            eraseGo_r <= eraseGo_nxt;
            progGo_r <= progGo_nxt;
            blockRead_r <= blockRead_nxt;
        end
    end
    assign opActive = active_r;
    assign writePermit = wel_r;
    assign haltedOp = halted_r;
    assign volatileLoss = volLoss_r;

    // Array update at cycle start: an aborted cycle still leaves the complete new data,
    // traded against holding a second copy of the page buffer
    genvar g;
    generate
        for (g = 0; g < fso_pkg::MEM_BYTES; g++) begin : g_mem
            logic [7:0] memNxt;
            always_comb begin
                memNxt = mem_r[g];
                if (eraseGo_r && (area_r == 2'(g / fso_pkg::AREA_BYTES))) begin
                    memNxt = fso_pkg::ERASED_BYTE;
                end else if (progGo_r && (area_r == 2'(g / fso_pkg::AREA_BYTES)) &&
                             (page_r == 2'((g % fso_pkg::AREA_BYTES) / fso_pkg::PAGE_BYTES))) begin
                    memNxt = mem_r[g] & pageBuf_r[g % fso_pkg::PAGE_BYTES]; // Program only clears bits
                end
            end
            always_ff @(posedge mclk or negedge rstN) begin
                if (!rstN) begin
                    mem_r[g] <= 8'hFF;
                end else begin
                    mem_r[g] <= memNxt;
                end
            end
        end
    endgenerate

    // Assertions
    property p_resume_ok;
        @(posedge mclk) disable iff (!rstN)
        csRise && (state_r != fso_pkg::ST_RSTWAIT) && isResume && !(isRst && rstArm_r) && halted_r && !active_r
        |=> !halted_r ##[0:RESUME_LAST] active_r;
    endproperty
    a_resume_ok: assert property (p_resume_ok) else $error("resume not taken in time");

    property p_resume_idle;
        @(posedge mclk) disable iff (!rstN)
        csRise && isResume && !halted_r && (state_r == fso_pkg::ST_IDLE) |=> !active_r;
    endproperty
    a_resume_idle: assert property (p_resume_idle) else $error("resume acted with nothing suspended");

    property p_erase_start;
        @(posedge mclk) disable iff (!rstN)
        csRise && eraseOk |=> active_r && (state_r == fso_pkg::ST_ERASE) && !wel_r ##1 eraseGo_r == 1'b0;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase did not start");

    property p_erase_end;
        @(posedge mclk) disable iff (!rstN)
        (state_r == fso_pkg::ST_ERASE) && active_r && (timer_r == 32'(ERASE_CYCLES - 1)) && !csRise
        |=> !active_r && (state_r == fso_pkg::ST_IDLE);
    endproperty
    a_erase_end: assert property (p_erase_end) else $error("erase length wrong");

    property p_busy_no_permit;
        @(posedge mclk) disable iff (!rstN)
        (state_r == fso_pkg::ST_ERASE || state_r == fso_pkg::ST_PROG) |-> !wel_r;
    endproperty
    a_busy_no_permit: assert property (p_busy_no_permit) else $error("permit set during cycle");

    property p_locked;
        @(posedge mclk) disable iff (!rstN)
        csRise && lockHit && (state_r == fso_pkg::ST_IDLE) && !isRst |=> state_r == fso_pkg::ST_IDLE;
    endproperty
    a_locked: assert property (p_locked) else $error("locked area changed");

    property p_no_permit;
        @(posedge mclk) disable iff (!rstN)
        csRise && !wel_r && (state_r == fso_pkg::ST_IDLE) |=> !active_r;
    endproperty
    a_no_permit: assert property (p_no_permit) else $error("operation without permit");

    property p_exact_len;
        @(posedge mclk) disable iff (!rstN)
        csRise && (opcode_r == fso_pkg::OP_ERASE) && (frameBits_r != eraseBits) && (state_r == fso_pkg::ST_IDLE)
        |=> state_r == fso_pkg::ST_IDLE;
    endproperty
    a_exact_len: assert property (p_exact_len) else $error("erase ran on wrong length");

    property p_prog_data;
        @(posedge mclk) disable iff (!rstN)
        csRise && (opcode_r == fso_pkg::OP_PROG) && (frameBits_r < progMin) && (state_r == fso_pkg::ST_IDLE)
        |=> state_r != fso_pkg::ST_PROG;
    endproperty
    a_prog_data: assert property (p_prog_data) else $error("program ran without data");

    property p_reset;
        @(posedge mclk) disable iff (!rstN)
        csRise && isRst && rstArm_r && (state_r != fso_pkg::ST_RSTWAIT)
        |=> (state_r == fso_pkg::ST_RSTWAIT) && volLoss_r && !wel_r && !halted_r && !active_r;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not applied");

    property p_rst_reject;
        @(posedge mclk) disable iff (!rstN)
        (state_r == fso_pkg::ST_RSTWAIT) |=> !active_r && !wel_r && (state_r != fso_pkg::ST_ERASE);
    endproperty
    a_rst_reject: assert property (p_rst_reject) else $error("command taken in recovery");

    property p_wrap;
        @(posedge sclk) disable iff (linkClr)
        rdAdv && (rdPtr_r == 11'h7FF) && (bitCnt_r != addrEnd) |=> rdPtr_r == 11'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("read offset did not wrap");

    c_resume: cover property (@(posedge mclk) disable iff (!rstN) halted_r ##1 !halted_r && active_r);
    c_erase: cover property (@(posedge mclk) disable iff (!rstN) eraseGo_r);
    c_prog: cover property (@(posedge mclk) disable iff (!rstN) progGo_r);
    c_reset: cover property (@(posedge mclk) disable iff (!rstN) volLoss_r);
endmodule : fso_core

// ### fso_host_model.sv
// Purpose: SPI host model for the security-area command block
// Assumes: Mode 0, shift clock period 125 ns, idle low between frames
// Notes: A released data line shows the inverse of its last bit
`timescale 1ns/1ps
module fso_host_model (
    output logic csN,
    output logic sclk,
    output logic si,
    input wire logic soData,
    input wire logic soOe
);
    // Link idle: deselected, clock stopped
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic frame(input logic [63:0] bits, input int n, input int rdBits, output logic [15:0] rd);
        rd = '0;
        csN = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = bits[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        si = ~si; // No stale bit left on the wire
        for (int i = 0; i < rdBits; i++) begin
            #62.5 sclk = 1'b1;
            rd = {rd[14:0], soData};
            #62.5 sclk = 1'b0;
        end
        #62.5 csN = 1'b1;
        #400; // Gap well above the 200 ns minimum
    endtask : frame
endmodule : fso_host_model

// ### fso_pkg.sv
// Purpose: Shared constants and types for the security-area command block
// Assumes: 20 MHz system clock; link clocked by the host shift clock
// Notes: Timing figures are plain defaults where no value is fixed
package fso_pkg;
    // Opcodes decoded by the block
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_ERASE = 8'h44;
    localparam logic [7:0] OP_PROG = 8'h42;
    localparam logic [7:0] OP_READ = 8'h48;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;

    // Security-area geometry
    localparam int AREA_CNT = 3;
    localparam int AREA_BYTES = 2048;
    localparam int PAGE_BYTES = 512;
    localparam int MEM_BYTES = AREA_CNT * AREA_BYTES;
    localparam logic [3:0] AREA_SEL_FIRST = 4'h1;
    localparam logic [3:0] AREA_SEL_LAST = 4'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Frame layout in link bits
    localparam logic [15:0] OPCODE_BITS = 16'h0008;
    localparam logic [15:0] ADDR_BITS_3B = 16'h0018;
    localparam logic [15:0] ADDR_BITS_4B = 16'h0020;
    localparam logic [15:0] DUMMY_BITS = 16'h0008;
    localparam logic [15:0] BIT_CNT_MAX = 16'hFFFF;

    // Timing: figures in their own unit, cycles derived from the clock rate
    localparam int MCLK_HZ = 20_000_000;
    localparam int RESUME_MAX_NS = 200;
    localparam int ERASE_TIME_US = 1000;
    localparam int PROG_TIME_US = 600;
    localparam int RST_TIME_US = 30;
    localparam int RESUME_CYCLES = (RESUME_MAX_NS * (MCLK_HZ / 1_000_000)) / 1000 < 1 ? 1 :
                                   (RESUME_MAX_NS * (MCLK_HZ / 1_000_000)) / 1000;
    localparam int ERASE_CYCLES = ERASE_TIME_US * (MCLK_HZ / 1_000_000);
    localparam int PROG_CYCLES = PROG_TIME_US * (MCLK_HZ / 1_000_000);
    localparam int RST_CYCLES = RST_TIME_US * (MCLK_HZ / 1_000_000);

    // Engine states
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_RSTWAIT} fso_state_t;
endpackage : fso_pkg

// ### tb_fso_core.sv
// Purpose: Self-checking bench for the security-area command block
// Assumes: Short erase, program and recovery counts set by parameters
// Notes: One four-byte read; all other addressed frames use three-byte addresses
`timescale 1ns/1ps
module tb_fso_core;
    logic mclk = 1'b0;
    logic arstN = 1'b0;
    logic [2:0] lockBits = 3'h0;
    logic wpSet = 1'b0;
    logic susReq = 1'b0;
    logic sawLoss = 1'b0;
    logic aw4 = 1'b0;
    logic oeSeen = 1'b0;
    logic csN, sclk, si, soData, soOe, opActive, writePermit, haltedOp, volatileLoss;
    logic [15:0] rd;
    int errCount = 0;
    int checkCount = 0;
    // Clock and a sticky copy of the one-cycle loss pulse
    always #25 mclk = ~mclk;
    always @(posedge mclk) if (volatileLoss === 1'b1) sawLoss <= 1'b1;
    // Sticky record that the serial output was enabled during a frame
    always @(posedge sclk) if (soOe === 1'b1) oeSeen <= 1'b1;
    fso_core #(.ERASE_CYCLES(200), .PROG_CYCLES(30), .RST_CYCLES(200)) fso_core_i (.mclk(mclk), .arst_n(arstN),
        .sclk(sclk), .csN(csN), .si(si), .otpLockBits(lockBits), .addrWidthSel(aw4), .writePermitSet(wpSet),
        .suspendReq(susReq), .soData(soData), .soOe(soOe), .opActive(opActive), .writePermit(writePermit),
        .haltedOp(haltedOp), .volatileLoss(volatileLoss));
    fso_host_model fso_host_model_i (.csN(csN), .sclk(sclk), .si(si), .soData(soData), .soOe(soOe));
    // Settle one step so edge updates have landed
    task automatic chk(input logic ok, input string msg);
        #1;
        checkCount++;
        if (ok !== 1'b1) begin
            errCount++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    // One-cycle side pulse: permit set or suspend request
    task automatic side(input logic w);
        @(posedge mclk);
        if (w) wpSet <= 1'b1;
        else susReq <= 1'b1;
        @(posedge mclk);
        wpSet <= 1'b0;
        susReq <= 1'b0;
    endtask : side
    task automatic sf(input logic [63:0] b, input int n, input int r);
        fso_host_model_i.frame(b, n, r, rd);
    endtask : sf
    task automatic idle();
        for (int i = 0; i < 400 && opActive !== 1'b0; i++) @(posedge mclk);
        chk(opActive === 1'b0, "cycle did not end");
    endtask : idle
    task automatic t_prog();
        side(1'b1);
        sf({8'h42, 24'h00_17FF, 16'hA53C}, 48, 0);
        chk(opActive === 1'b1 && writePermit === 1'b0, "program not started");
        idle();
        sf({8'h48, 24'h00_17FF, 8'h00}, 40, 16);
        chk(rd === 16'hA5FF && oeSeen === 1'b1, "read wrap data");
        @(posedge mclk) aw4 <= 1'b1;
        sf({8'h48, 32'h0000_17FF, 8'h00}, 48, 16);
        chk(rd === 16'hA5FF, "four-byte read data");
        @(posedge mclk) aw4 <= 1'b0;
        $display("test prog done");
    endtask : t_prog
    task automatic t_erase();
        sf({8'h44, 24'h00_1000}, 32, 0);
        chk(opActive === 1'b0, "erase without permit ran");
        side(1'b1);
        lockBits <= 3'h1;
        sf({8'h44, 24'h00_1000}, 32, 0);
        chk(opActive === 1'b0, "locked erase ran");
        @(posedge mclk) lockBits <= 3'h0;
        sf({8'h44, 24'h00_1000, 1'b0}, 33, 0);
        chk(opActive === 1'b0, "long erase frame ran");
        sf({8'h44, 24'h00_1000}, 32, 0);
        chk(opActive === 1'b1 && writePermit === 1'b0, "erase not started");
        idle();
        sf({8'h48, 24'h00_17FF, 8'h00}, 40, 16);
        chk(rd === 16'hFFFF, "erase left data");
        $display("test erase done");
    endtask : t_erase
    task automatic t_resume();
        side(1'b1);
        sf({8'h42, 24'h00_2000, 8'h00}, 40, 0);
        side(1'b0);
        // Look away from the edge that launches the halt
        @(negedge mclk);
        chk(haltedOp === 1'b1 && opActive === 1'b0, "suspend failed");
        sf(8'h7A, 8, 0);
        chk(haltedOp === 1'b0 && opActive === 1'b1, "resume refused");
        idle();
        sf(8'h7A, 8, 0);
        chk(opActive === 1'b0, "stray resume ran");
        $display("test resume done");
    endtask : t_resume
    task automatic t_reset();
        side(1'b1);
        sf({8'h44, 24'h00_3000}, 32, 0);
        chk(opActive === 1'b1 && haltedOp === 1'b0, "erase not running before reset");
        sf(8'h66, 8, 0);
        sf(8'h99, 8, 0);
        chk(sawLoss === 1'b1 && opActive === 1'b0 && writePermit === 1'b0, "reset not taken");
        oeSeen = 1'b0;
        // Erased byte, so a read that slipped through would show FF
        sf({8'h48, 24'h00_2001, 8'h00}, 40, 8);
        chk(rd[7:0] === 8'h00 && oeSeen === 1'b0, "read during recovery");
        $display("test reset done");
    endtask : t_reset
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge mclk);
        arstN <= 1'b1;
        repeat (4) @(posedge mclk);
        t_prog();
        t_erase();
        t_resume();
        t_reset();
        report_and_stop();
    end
    // Watchdog far beyond the expected 100 us of traffic
    initial begin
        #1_000_000;
        errCount++;
        $display("Error at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb_fso_core
